// file: design/tda_pkg.sv
// Package holding the register map, field layouts and carrier types of the input aligner
package tda_pkg;
    // Register map (printed offsets, byte-wide address space)
    localparam logic [7:0] TDA_LOCAL_DELAY_BASE = 8'h23;
    localparam logic [7:0] TDA_LOCAL_DELAY_LAST = 8'h42;
    localparam logic [7:0] TDA_BP_DELAY_BASE = 8'h43;
    localparam logic [7:0] TDA_BP_DELAY_LAST = 8'h62;
    // Field layouts
    localparam int TDA_LOCAL_FIELD_W = 5;
    localparam int TDA_BP_CHAN_W = 9;
    localparam int TDA_REG_W = 16;
    localparam int TDA_POINT_W = 2;
    // Reset values
    localparam logic [TDA_LOCAL_FIELD_W-1:0] TDA_LOCAL_RESET = 5'h00;
    localparam logic [TDA_REG_W-1:0] TDA_BP_RESET = 16'h0000;
    // Timing counts in quarter-bit and bit units
    localparam int TDA_QUARTERS_PER_BIT = 4;
    localparam int TDA_BITS_PER_CHAN = 8;
    localparam int TDA_FRAME_BIT_W = 12;
    // Quarter-bit history depth: 3/4 point plus 7 3/4 bits of delay
    localparam int TDA_HIST_DEPTH = 33;
    // History tap for each sampling point, counted back from the 4/4 sample
    localparam logic [5:0] TDA_TAP_3Q = 6'h01;
    localparam logic [5:0] TDA_TAP_4Q = 6'h00;
    localparam logic [5:0] TDA_TAP_1Q = 6'h03;
    localparam logic [5:0] TDA_TAP_2Q = 6'h02;

    // Register port request
    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [TDA_REG_W-1:0] wdata;
    } tda_reg_req_t;

    // One stored backplane channel
    typedef struct packed {
        logic valid;
        logic [TDA_BP_CHAN_W-1:0] chan;
        logic [7:0] data;
    } tda_bp_store_t;
endpackage

// file: design/tda_input_align.sv
// Per-stream bit delay, sampling point and channel delay alignment of TDM inputs
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE1 - Mode low: delay equals field over four
// RULE2 - Mode low: sample at 3/4 plus delay
// RULE3 - Mode high: low bits pick sampling point
// RULE4 - Mode high: upper bits give whole-bit delay
// RULE5 - Thirty-two backplane channel delay registers, consecutive
// RULE6 - Nine low bits postpone storage by channels
// RULE7 - Software keeps delay within stream rate
// RULE8 - Software writes zero to upper seven bits
// RULE9 - Thirty-two local bit delay registers, five bits
// RULE10 - New values take effect at frame boundary
module tda_input_align
    import tda_pkg::*;
#(
    parameter int NUM_STREAMS = 32
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire tda_reg_req_t reg_req_in,
    output var logic [TDA_REG_W-1:0] reg_rdata_out,
    input wire logic sample_point_select_mode_in,
    input wire logic quarter_tick_in,
    input wire logic frame_start_in,
    input wire logic [NUM_STREAMS-1:0] local_serial_input_in,
    input wire logic [NUM_STREAMS-1:0] backplane_serial_input_in,
    output var logic [NUM_STREAMS-1:0] local_bit_out,
    output var logic local_bit_valid_out,
    output var tda_bp_store_t [NUM_STREAMS-1:0] backplane_store_out
);

    initial begin
        if (NUM_STREAMS < 1 || NUM_STREAMS > 32) begin
            $error("NUM_STREAMS must lie between 1 and 32");
        end
        // The deepest tap must still lie inside the quarter-bit history
        if (TDA_HIST_DEPTH < 33) begin
            $error("quarter history too short for the deepest tap");
        end
        // The byte assembler below is built for eight bits per channel
        if (TDA_BITS_PER_CHAN != 8) begin
            $error("channel assembly assumes eight bits per channel");
        end
        // Four quarters per bit is wired into the two-bit phase counter
        if (TDA_QUARTERS_PER_BIT != 4) begin
            $error("phase counter assumes four quarters per bit");
        end
        // The channel number must fit the nine-bit channel delay
        if (TDA_FRAME_BIT_W - 3 != TDA_BP_CHAN_W) begin
            $error("frame bit counter does not match the channel width");
        end
        // The tap function is written for a five-bit delay field
        if (TDA_LOCAL_FIELD_W != 5) begin
            $error("tap selection assumes a five-bit delay field");
        end
    end

    // History tap for a local stream; widened so 31 + 1 cannot wrap
    function automatic logic [5:0] tap_index(input logic mode, input logic [4:0] field);
        logic [5:0] point;
        point = TDA_TAP_3Q;
        if (!mode) begin
            return {1'b0, field} + TDA_TAP_3Q; // [RULE1] [RULE2]
        end
        unique case (field[1:0])
            2'b00: point = TDA_TAP_3Q; // [RULE3]
            2'b01: point = TDA_TAP_4Q;
            2'b10: point = TDA_TAP_1Q;
            2'b11: point = TDA_TAP_2Q;
        endcase
        return {1'b0, field[4:2], 2'b00} + point; // [RULE4]
    endfunction

    // Quarter phase and frame bit position shared by all streams
    logic [1:0] phase;
    logic bit_end;
    logic [TDA_FRAME_BIT_W-1:0] bit_count;
    logic frame_tick;
    logic [1:0] next_phase;
    logic byte_end;
    logic [TDA_BP_CHAN_W-1:0] chan_now;

    assign frame_tick = quarter_tick_in && frame_start_in;
    assign next_phase = frame_start_in ? 2'h0 : 2'(phase + 2'h1);
    assign byte_end = bit_end && (bit_count[2:0] == 3'(TDA_BITS_PER_CHAN - 1));
    assign chan_now = bit_count[TDA_FRAME_BIT_W-1:3];

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            phase <= 2'h0;
        end else if (quarter_tick_in) begin
            phase <= next_phase;
        end
    end

    // Bit end lags the last quarter tick by one cycle so the history has shifted
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            bit_end <= 1'b0;
        end else begin
            bit_end <= quarter_tick_in && (next_phase == 2'(TDA_QUARTERS_PER_BIT - 1));
        end
    end

    // Bit position counts from each frame boundary; wraps if a frame pulse is missed
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            bit_count <= '0;
        end else if (frame_tick) begin
            bit_count <= '0;
        end else if (bit_end) begin
            bit_count <= TDA_FRAME_BIT_W'(bit_count + 1'b1);
        end
    end

    // Register decode
    logic local_hit;
    logic bp_hit;
    logic [7:0] local_idx;
    logic [7:0] bp_idx;
    logic [4:0] local_sel;
    logic [4:0] bp_sel;

    assign local_hit = reg_req_in.sel && reg_req_in.addr >= TDA_LOCAL_DELAY_BASE
        && reg_req_in.addr <= TDA_LOCAL_DELAY_LAST
        && local_idx < 8'(NUM_STREAMS);
    assign bp_hit = reg_req_in.sel && reg_req_in.addr >= TDA_BP_DELAY_BASE
        && reg_req_in.addr <= TDA_BP_DELAY_LAST
        && bp_idx < 8'(NUM_STREAMS);
    assign local_idx = 8'(reg_req_in.addr - TDA_LOCAL_DELAY_BASE);
    assign bp_idx = 8'(reg_req_in.addr - TDA_BP_DELAY_BASE);
    assign local_sel = local_idx[4:0];
    assign bp_sel = bp_idx[4:0];

    // Programmed values and the copies in force for the current frame
    logic [TDA_LOCAL_FIELD_W-1:0] local_delay [NUM_STREAMS];
    logic [TDA_REG_W-1:0] bp_delay [NUM_STREAMS];
    logic [TDA_LOCAL_FIELD_W-1:0] local_active [NUM_STREAMS];
    logic [TDA_BP_CHAN_W-1:0] bp_active [NUM_STREAMS];

    // Read data: unmapped addresses and the reserved bits of local registers answer zero
    logic [TDA_REG_W-1:0] local_read;
    logic [TDA_REG_W-1:0] bp_read;
    logic [TDA_REG_W-1:0] read_value;
    // Reserved bits of a local register are not stored, so they read back zero
    assign local_read = TDA_REG_W'(local_delay[local_sel]); // [RULE9]
    // Backplane registers keep all sixteen bits as written
    assign bp_read = bp_delay[bp_sel]; // [RULE5]
    assign read_value = local_hit ? local_read : bp_hit ? bp_read : '0;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= '0;
        end else if (reg_req_in.sel && !reg_req_in.wr) begin
            reg_rdata_out <= read_value;
        end
    end

    // Serial pins pass two flip-flops before use
    logic [NUM_STREAMS-1:0] local_sync1;
    logic [NUM_STREAMS-1:0] local_sync2;
    logic [NUM_STREAMS-1:0] bp_sync1;
    logic [NUM_STREAMS-1:0] bp_sync2;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            local_sync1 <= '0;
            local_sync2 <= '0;
        end else begin
            local_sync1 <= local_serial_input_in;
            local_sync2 <= local_sync1;
        end
    end

    // Backplane pins get the same two stages; only the second stage is read
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            bp_sync1 <= '0;
            bp_sync2 <= '0;
        end else begin
            bp_sync1 <= backplane_serial_input_in;
            bp_sync2 <= bp_sync1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            local_bit_valid_out <= 1'b0;
        end else begin
            local_bit_valid_out <= bit_end;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NUM_STREAMS; s++) begin : g_stream
            logic [TDA_HIST_DEPTH-1:0] local_hist;
            logic [1:0] bp_hist;
            logic [6:0] bp_shift;
            logic [5:0] tap;
            logic store_now;
            logic local_write;
            logic bp_write;
            logic bp_bit;

            assign tap = tap_index(sample_point_select_mode_in, local_active[s]);
            // Channels before the programmed delay are not stored
            assign store_now = byte_end && (chan_now >= bp_active[s]); // [RULE6]

            // Per-stream write strobes
            assign local_write = reg_req_in.wr && local_hit && local_sel == 5'(s);
            assign bp_write = reg_req_in.wr && bp_hit && bp_sel == 5'(s);

            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    local_delay[s] <= TDA_LOCAL_RESET; // [RULE9]
                end else if (local_write) begin
                    local_delay[s] <= reg_req_in.wdata[TDA_LOCAL_FIELD_W-1:0]; // [RULE9]
                end
            end

            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    bp_delay[s] <= TDA_BP_RESET; // [RULE5]
                end else if (bp_write) begin
                    bp_delay[s] <= reg_req_in.wdata; // [RULE5]
                end
            end

            // Each stream picks up its own new value only on a frame boundary
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    local_active[s] <= TDA_LOCAL_RESET;
                end else if (frame_tick) begin
                    local_active[s] <= local_delay[s]; // [RULE10]
                end
            end

            // Upper bits are assumed zero and are not used
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    bp_active[s] <= '0;
                end else if (frame_tick) begin
                    bp_active[s] <= bp_delay[s][TDA_BP_CHAN_W-1:0]; // [RULE10] [RULE8]
                end
            end

            // History holds one sample per quarter, newest in bit zero
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    local_hist <= '0;
                end else if (quarter_tick_in) begin
                    local_hist <= {local_hist[TDA_HIST_DEPTH-2:0], local_sync2[s]};
                end
            end

            // Backplane needs only the last two quarters for its fixed point
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    bp_hist <= '0;
                end else if (quarter_tick_in) begin
                    bp_hist <= {bp_hist[0], bp_sync2[s]};
                end
            end

            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    local_bit_out[s] <= 1'b0;
                end else if (bit_end) begin
                    local_bit_out[s] <= local_hist[tap]; // [RULE1] [RULE3] [RULE4]
                end
            end

            // Backplane bits taken at the 3/4 point, first bit in the MSB
            assign bp_bit = bp_hist[TDA_TAP_3Q[0]];

            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    bp_shift <= '0;
                end else if (bit_end) begin
                    bp_shift <= {bp_shift[5:0], bp_bit};
                end
            end

            // A byte is stored only once the programmed channel count has passed
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    backplane_store_out[s] <= '0;
                end else begin
                    backplane_store_out[s].valid <= store_now; // [RULE6]
                    if (store_now) begin
                        backplane_store_out[s].chan <= TDA_BP_CHAN_W'(chan_now - bp_active[s]);
                        backplane_store_out[s].data <= {bp_shift, bp_bit};
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: verif/tda_align_chk_assertions.sv
// Port checker for the input aligner, bound into every instance
`timescale 1ns/1ns
`default_nettype none
module tda_align_chk
    import tda_pkg::*;
#(
    parameter int NUM_STREAMS = 32
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire tda_reg_req_t reg_req_in,
    input wire logic [TDA_REG_W-1:0] reg_rdata_out,
    input wire logic quarter_tick_in,
    input wire logic [NUM_STREAMS-1:0] local_bit_out,
    input wire logic local_bit_valid_out,
    input wire tda_bp_store_t [NUM_STREAMS-1:0] backplane_store_out
);
    wire logic rd = reg_req_in.sel && !reg_req_in.wr;
    wire logic bp_wr = reg_req_in.sel && reg_req_in.wr
        && reg_req_in.addr inside {[TDA_BP_DELAY_BASE:TDA_BP_DELAY_LAST]};
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    rd_hold_a: assert property (!rd |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    rd_unmapped_a: assert property (rd && (reg_req_in.addr < TDA_LOCAL_DELAY_BASE
        || reg_req_in.addr > TDA_BP_DELAY_LAST) |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    rd_local_a: assert property (rd && reg_req_in.addr inside
        {[TDA_LOCAL_DELAY_BASE:TDA_LOCAL_DELAY_LAST]} |=> reg_rdata_out[15:5] == 11'h000)
        else $error("local reserved bits read nonzero");
    bp_readback_a: assert property (bp_wr
        ##2 (rd && reg_req_in.addr == $past(reg_req_in.addr, 2))
        |=> reg_rdata_out == $past(reg_req_in.wdata, 3))
        else $error("channel delay readback wrong");
    bit_hold_a: assert property ($changed(local_bit_out) |-> local_bit_valid_out)
        else $error("aligned bit moved without valid");
    bit_tick_a: assert property (local_bit_valid_out |-> $past(quarter_tick_in, 2))
        else $error("aligned bit not two cycles after a tick");
    store_pulse_a: assert property (backplane_store_out[0].valid |=> !backplane_store_out[0].valid)
        else $error("store valid longer than one cycle");
    store_hold_a: assert property (!backplane_store_out[0].valid |->
        $stable(backplane_store_out[0].chan) && $stable(backplane_store_out[0].data))
        else $error("stored channel moved without store");
endmodule
bind tda_input_align tda_align_chk #(.NUM_STREAMS(NUM_STREAMS)) chk_u (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .quarter_tick_in(quarter_tick_in), .local_bit_out(local_bit_out),
    .local_bit_valid_out(local_bit_valid_out), .backplane_store_out(backplane_store_out));
`default_nettype wire

// file: verif/tda_stream_src.sv
// Serial stream source: quarter ticks, 32-bit frames and pin patterns
`timescale 1ns/1ns
`default_nettype none
module tda_stream_src (
    input wire logic clock_in,
    input wire logic reset_n_in,
    output logic tick_out,
    output logic frame_out,
    output logic [31:0] local_pin_out,
    output logic [31:0] bp_pin_out
);
    logic [1:0] cyc;
    logic [6:0] quarter;
    wire logic [6:0] nq = quarter + 7'h01;
    wire logic [7:0] chan_byte = 8'h5a ^ ({6'h00, nq[6:5]} * 8'h27);
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            {cyc, tick_out, frame_out, local_pin_out, bp_pin_out} <= '0;
            quarter <= 7'h7f;
        end else begin
            cyc <= cyc + 2'h1;
            tick_out <= (cyc == 2'h3);
            frame_out <= (cyc == 2'h3) && (nq == 7'h00);
            if (cyc == 2'h3) begin
                quarter <= nq;
            end
            // Set one tick early to cover the receiver's sync delay
            if (tick_out) begin
                // Local pins change every quarter so each sampling slot is visible
                local_pin_out <= {32{^(nq * 7'h1b)}};
                bp_pin_out <= {32{chan_byte[~nq[4:2]]}};
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/tda_input_align_tb.sv
// Testbench for the input aligner: register port, bit alignment, channel delay
`timescale 1ns/1ns
`default_nettype none
module tda_input_align_tb;
    import tda_pkg::*;
    logic clock_in, reset_n_in, mode, tick, frame, valid;
    logic [31:0] lpin, bpin, lbit;
    logic [15:0] rdata;
    tda_reg_req_t req;
    tda_bp_store_t [31:0] store;
    int failures = 0;
    int total_checks = 0;
    tda_input_align dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .sample_point_select_mode_in(mode), .quarter_tick_in(tick),
        .frame_start_in(frame), .local_serial_input_in(lpin), .backplane_serial_input_in(bpin),
        .local_bit_out(lbit), .local_bit_valid_out(valid), .backplane_store_out(store));
    tda_stream_src src_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .tick_out(tick),
        .frame_out(frame), .local_pin_out(lpin), .bp_pin_out(bpin));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic reg_io(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        req <= '{sel: 1'b1, wr: wr, addr: a, wdata: d};
        @(posedge clock_in);
        req <= '0;
    endtask
    // First pass lets the new delays load at a frame tick, second pass checks a whole frame
    task automatic run_field(input logic m, input logic [4:0] f);
        logic [8:0] bd [2];
        logic [4:0] d;
        logic [1:0] s;
        int j, n, stores [2];
        bd[0] = 9'(f % 5);
        bd[1] = 9'((f + 2) % 5);
        d = m ? {f[4:2], 2'b00} : f;
        s = m ? f[1:0] ^ 2'b10 : 2'b10;
        reg_io(1'b1, TDA_LOCAL_DELAY_BASE, {11'h000, f});
        reg_io(1'b1, TDA_BP_DELAY_BASE, {7'h00, bd[0]});
        reg_io(1'b1, TDA_BP_DELAY_BASE + 8'h01, {7'h00, bd[1]});
        mode <= m;
        for (int pass = 0; pass < 2; pass++) begin
            j = 0;
            n = 0;
            stores = '{0, 0};
            do begin
                @(negedge clock_in);
                n++;
                if (valid && pass == 1) begin
                    chk("local bit", {15'h0000, ^(7'(4 * j + s - d) * 7'h1b)},
                        {15'h0000, lbit[0]});
                    j++;
                end
                for (int k = 0; k < 2; k++) begin
                    if (store[k].valid && pass == 1) begin
                        chk("stored chan", 16'(stores[k]),
                            {7'h00, store[k].chan});
                        chk("stored byte",
                            {8'h00, 8'h5a ^ (8'(stores[k] + bd[k]) * 8'h27)},
                            {8'h00, store[k].data});
                        stores[k]++;
                    end
                end
            end while (!frame && n < 600);
            if (!frame) begin
                failures++;
                end_of_test();
            end
        end
        chk("bits per frame", 16'h0020, 16'(j));
        for (int k = 0; k < 2; k++) begin
            chk("stores per frame", 16'(4 - bd[k]), 16'(stores[k]));
        end
    endtask
    initial begin
        logic [7:0] bad [3];
        logic [15:0] v;
        bad = '{8'h22, 8'h63, 8'hff};
        reset_n_in = 1'b0;
        req = '0;
        mode = 1'b0;
        repeat (10) @(posedge clock_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            v = 16'h0100 + 16'(3 * i);
            reg_io(1'b0, TDA_LOCAL_DELAY_BASE + 8'(i), 16'h0000);
            @(negedge clock_in);
            chk("reset value", 16'h0000, rdata);
            reg_io(1'b1, TDA_LOCAL_DELAY_BASE + 8'(i), v);
            reg_io(1'b0, TDA_LOCAL_DELAY_BASE + 8'(i), 16'h0000);
            @(negedge clock_in);
            chk("read back", (i < 32) ? (v & 16'h001f) : v, rdata);
        end
        for (int i = 0; i < 3; i++) begin
            reg_io(1'b1, bad[i], 16'h0155);
            reg_io(1'b0, bad[i], 16'h0000);
            @(negedge clock_in);
            chk("unmapped read", 16'h0000, rdata);
        end
        for (int m = 0; m < 2; m++) begin
            for (int f = 0; f < 32; f++) begin
                run_field(1'(m), 5'(f));
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
